// [hw/pwm_bridge_map.vh]
// Register indices, field positions, reset values and timing constants of the bridge PWM
`ifndef PWM_BRIDGE_MAP_VH
`define PWM_BRIDGE_MAP_VH

// ****************************************************************
// Register indices on the write port
// ****************************************************************
`define IDX_CONFIG        6'h24
`define IDX_DUTY_ONE      6'h25
`define IDX_DUTY_TWO      6'h26
`define IDX_DUTY_THREE    6'h27
`define IDX_DUTY_FOUR     6'h28

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define CFG_TOP_MSB       11
`define CFG_TOP_LSB       0
`define CFG_MODE_BASE     16
`define CFG_MODE_STRIDE   4
`define CFG_ALIGN_MSB     33
`define CFG_ALIGN_LSB     32
`define CFG_POL_LOW       40
`define CFG_POL_HIGH      41
`define CFG_POL_AB        42
`define CFG_POL_B         43
`define CFG_POL_CENTER    44
`define CFG_POL_A         45
`define CFG_POL_ZERO      46
`define CFG_DT_LOW_MSB    55
`define CFG_DT_LOW_LSB    48
`define CFG_DT_HIGH_MSB   63
`define CFG_DT_HIGH_LSB   56
`define DUTY_MSB          11

// ****************************************************************
// Reset values
// ****************************************************************
`define CONFIG_RESET      64'h0000_0000_0000_0000
`define DUTY_RESET        12'h000
`define COUNT_ZERO        12'h000

// ****************************************************************
// Alignment and chopper mode codes
// ****************************************************************
`define ALIGN_LEFT        2'h0
`define ALIGN_RIGHT       2'h1
`define ALIGN_CENTER      2'h2
`define MODE_OFF          3'h0
`define MODE_COMPL        3'h1
`define MODE_HIGH_ONLY    3'h2
`define MODE_LOW_ONLY     3'h3

// ****************************************************************
// Dead time timing: ticks in 10 ns units, clock period 50 ns
// ****************************************************************
`define CLK_PERIOD_NS     50
`define DT_TICK_NS        10
`define DT_TICKS_PER_CLK  (`CLK_PERIOD_NS / `DT_TICK_NS)

`endif

// [hw/dead_time_gate.v]
// One gate output with break-before-make delay on switch-on and selectable polarity
`include "pwm_bridge_map.vh"
module dead_time_gate #(
   parameter DT_WIDTH = 8
) (
   // Clock and reset
   input  wire                ref_clk,
   input  wire                nrst,
   // Control
   input  wire                want_on,
   input  wire [DT_WIDTH-1:0] dead_ticks,
   input  wire                invert,
   // Gate pin
   output reg                 gate_out
);

   localparam CW = DT_WIDTH + 3;
   localparam integer  STEP_FULL = `DT_TICKS_PER_CLK;
   localparam [CW-1:0] STEP      = STEP_FULL[CW-1:0];

   reg  [CW-1:0] elapsed;
   reg           next_on;
   wire          done;

   // Elapsed time has covered the dead time
   assign done = (elapsed >= {3'h0, dead_ticks});

   // Switch-on waits out the dead time, switch-off is immediate
   always @* begin
      next_on = want_on & done;
   end

   // Dead time counter in 10 ns units and registered pin
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         elapsed  <= {CW{1'b0}};
         gate_out <= 1'b0;
      end else begin
         if (!want_on) begin
            elapsed <= {CW{1'b0}};
         end else if (!done) begin
            elapsed <= elapsed + STEP;
         end
         gate_out <= next_on ^ invert;
      end
   end

endmodule // dead_time_gate

// [hw/four_channel_bridge_pwm.v]
// Four-channel bridge PWM: shared counter, duty registers, chopper, dead time, trigger pulses
//
// Summary of operation
// - Each channel keeps a 12-bit on-time register; counter top is programmable too.
// - Each channel has a 3-bit chopper mode at config bits 18:16..30:28.
// - One 2-bit alignment field applies to all four channels alike.
// - Config bit 40 inverts all low-side gates, bit 41 all high-side gates.
// - Bits 42..46 set polarity of AB, B, center, A and zero pulses.
// - Low-side gates wait bits 55:48 ticks of 10 ns before switching on.
// - High-side gates wait bits 63:56 ticks of 10 ns before switching on.
`include "pwm_bridge_map.vh"

module four_channel_bridge_pwm #(
   parameter CH       = 4,
   parameter CW       = 12,
   parameter DT_WIDTH = 8
) (
   // Clock and reset
   input  wire          ref_clk,
   input  wire          nrst,
   // Network-side register write port
   input  wire          net_wr_en,
   input  wire [5:0]    net_wr_index,
   input  wire [63:0]   net_wr_data,
   // Host-side register write port
   input  wire          host_wr_en,
   input  wire [5:0]    host_wr_index,
   input  wire [63:0]   host_wr_data,
   // Trigger pulse positions
   input  wire [CW-1:0] pulse_a_pos,
   input  wire [CW-1:0] pulse_b_pos,
   // Gate outputs, bit n is channel n+1
   output wire [CH-1:0] gate_high,
   output wire [CH-1:0] gate_low,
   // Trigger pulse outputs
   output reg           pulse_zero,
   output reg           pulse_center,
   output reg           pulse_a,
   output reg           pulse_b,
   output reg           pulse_ab,
   // Counter state
   output reg  [CW-1:0] pwm_count,
   output reg           count_down
);

   // ****************************************************************
   // Register write port
   // ****************************************************************

   reg  [63:0]      pwm_unit_config;
   reg  [CW-1:0]    duty [0:CH-1];
   reg              wr_en;
   reg  [5:0]       wr_index;
   reg  [63:0]      wr_data;
   integer          i;

   // Network side wins when both ports write in the same cycle
   always @* begin
      wr_en    = net_wr_en | host_wr_en;
      wr_index = net_wr_en ? net_wr_index : host_wr_index;
      wr_data  = net_wr_en ? net_wr_data : host_wr_data;
   end

   // Maps a register index to a duty channel, CH when not a duty register
   function [2:0] duty_slot;
      input [5:0] idx;
      begin
         case (idx)
            `IDX_DUTY_ONE:   duty_slot = 3'h0;
            `IDX_DUTY_TWO:   duty_slot = 3'h1;
            `IDX_DUTY_THREE: duty_slot = 3'h2;
            `IDX_DUTY_FOUR:  duty_slot = 3'h3;
            default:         duty_slot = 3'h4;
         endcase
      end
   endfunction

   // Configuration and duty storage, write-only from software
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_unit_config <= `CONFIG_RESET;
         for (i = 0; i < CH; i = i + 1) begin
            duty[i] <= `DUTY_RESET;
         end
      end else if (wr_en) begin
         if (wr_index == `IDX_CONFIG) begin
            pwm_unit_config <= wr_data;
         end
         for (i = 0; i < CH; i = i + 1) begin
            if (duty_slot(wr_index) == i[2:0]) begin
               duty[i] <= wr_data[`DUTY_MSB:0];
            end
         end
      end
   end

   // ****************************************************************
   // Configuration fields
   // ****************************************************************

   wire [CW-1:0]       top_value;
   wire [1:0]          align;
   wire                pol_low;
   wire                pol_high;
   wire [DT_WIDTH-1:0] dt_low;
   wire [DT_WIDTH-1:0] dt_high;

   assign top_value = pwm_unit_config[`CFG_TOP_MSB:`CFG_TOP_LSB];
   assign align     = pwm_unit_config[`CFG_ALIGN_MSB:`CFG_ALIGN_LSB];
   assign pol_low   = pwm_unit_config[`CFG_POL_LOW];
   assign pol_high  = pwm_unit_config[`CFG_POL_HIGH];
   assign dt_low    = pwm_unit_config[`CFG_DT_LOW_MSB:`CFG_DT_LOW_LSB];
   assign dt_high   = pwm_unit_config[`CFG_DT_HIGH_MSB:`CFG_DT_HIGH_LSB];

   // ****************************************************************
   // Shared counter
   // ****************************************************************

   reg  [CW-1:0] next_count;
   reg           next_down;
   wire          centered;

   assign centered = (align == `ALIGN_CENTER) | (align == 2'h3);

   // Sawtooth for edge alignment, up/down triangle for center alignment
   always @* begin
      next_count = pwm_count;
      next_down  = 1'b0;
      if (top_value == `COUNT_ZERO) begin
         next_count = `COUNT_ZERO;
      end else if (!centered) begin
         next_count = (pwm_count >= top_value) ? `COUNT_ZERO : pwm_count + 1'b1;
      end else if (!count_down) begin
         next_count = (pwm_count >= top_value) ? pwm_count - 1'b1 : pwm_count + 1'b1;
         next_down  = (pwm_count + 1'b1 >= top_value) | (pwm_count >= top_value);
      end else begin
         next_count = pwm_count - 1'b1;
         next_down  = (pwm_count > 12'h001);
      end
   end

   // Counter and direction flops
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_count  <= `COUNT_ZERO;
         count_down <= 1'b0;
      end else begin
         pwm_count  <= next_count;
         count_down <= next_down;
      end
   end

   // ****************************************************************
   // Trigger pulses
   // ****************************************************************

   // One-cycle events at zero, top, and the A and B positions
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pulse_zero   <= 1'b0;
         pulse_center <= 1'b0;
         pulse_a      <= 1'b0;
         pulse_b      <= 1'b0;
         pulse_ab     <= 1'b0;
      end else begin
         pulse_zero   <= (next_count == `COUNT_ZERO) ^ pwm_unit_config[`CFG_POL_ZERO];
         pulse_center <= (next_count == top_value) ^ pwm_unit_config[`CFG_POL_CENTER];
         pulse_a      <= (next_count == pulse_a_pos) ^ pwm_unit_config[`CFG_POL_A];
         pulse_b      <= (next_count == pulse_b_pos) ^ pwm_unit_config[`CFG_POL_B];
         pulse_ab     <= ((next_count == pulse_a_pos) | (next_count == pulse_b_pos))
                         ^ pwm_unit_config[`CFG_POL_AB];
      end
   end

   // ****************************************************************
   // Channels: compare, chopper, dead time
   // ****************************************************************

   genvar g;
   generate
      for (g = 0; g < CH; g = g + 1) begin : chan
         wire [2:0] mode;
         reg        active;
         reg        want_high;
         reg        want_low;

         assign mode = pwm_unit_config[`CFG_MODE_BASE + g*`CFG_MODE_STRIDE +: 3];

         // On-phase from the shared counter under the common alignment
         always @* begin
            if (align == `ALIGN_RIGHT) begin
               active = ((top_value - pwm_count) < duty[g]);
            end else begin
               active = (pwm_count < duty[g]);
            end
         end

         // Chopper mode picks which gates follow the on-phase
         always @* begin
            case (mode)
               `MODE_COMPL: begin
                  want_high = active;
                  want_low  = ~active;
               end
               `MODE_HIGH_ONLY: begin
                  want_high = active;
                  want_low  = 1'b0;
               end
               `MODE_LOW_ONLY: begin
                  want_high = 1'b0;
                  want_low  = active;
               end
               default: begin
                  want_high = 1'b0;
                  want_low  = 1'b0;
               end
            endcase
         end

         // High-side gate with its own dead time and polarity
         dead_time_gate #(
            .DT_WIDTH (DT_WIDTH)
         ) u_high (
            .ref_clk    (ref_clk),
            .nrst       (nrst),
            .want_on    (want_high),
            .dead_ticks (dt_high),
            .invert     (pol_high),
            .gate_out   (gate_high[g])
         );

         // Low-side gate with its own dead time and polarity
         dead_time_gate #(
            .DT_WIDTH (DT_WIDTH)
         ) u_low (
            .ref_clk    (ref_clk),
            .nrst       (nrst),
            .want_on    (want_low),
            .dead_ticks (dt_low),
            .invert     (pol_low),
            .gate_out   (gate_low[g])
         );
      end
   endgenerate

endmodule // four_channel_bridge_pwm

// [sim/pwm_bridge_sva.sv]
// Checker of counter, trigger pulse and gate timing of the bridge PWM
`include "pwm_bridge_map.vh"
module pwm_bridge_sva #(
   parameter CH = 4,
   parameter CW = 12
) (
   // Clock and reset
   input wire logic          ref_clk,
   input wire logic          nrst,
   // Write ports
   input wire logic          net_wr_en,
   input wire logic [5:0]    net_wr_index,
   input wire logic [63:0]   net_wr_data,
   input wire logic          host_wr_en,
   input wire logic [5:0]    host_wr_index,
   input wire logic [63:0]   host_wr_data,
   // Outputs watched
   input wire logic [CH-1:0] gate_high,
   input wire logic [CH-1:0] gate_low,
   input wire logic          pulse_zero,
   input wire logic [CW-1:0] pwm_count,
   input wire logic          count_down
);
   // ********
   // Shadow configuration
   // ********
   logic [63:0] c;
   logic [3:0]  quiet;
   wire         calm = quiet > 4'h3 && !net_wr_en && !host_wr_en;
   // Net side wins a shared cycle; quiet counts cycles since any write
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         c     <= 64'h0;
         quiet <= 4'h0;
      end else begin
         if (net_wr_en && net_wr_index == `IDX_CONFIG) c <= net_wr_data;
         else if (host_wr_en && !net_wr_en && host_wr_index == `IDX_CONFIG) c <= host_wr_data;
         if (net_wr_en || host_wr_en) quiet <= 4'h0;
         else if (quiet != 4'hf) quiet <= quiet + 4'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Channel one settled in complementary mode with plain polarity
   sequence compl0;
      calm && c[18:16] == `MODE_COMPL && c[41:40] == 2'h0;
   endsequence
   count_step_a: assert property (
      calm && !c[33] && pwm_count < c[11:0] |=> pwm_count == $past(pwm_count) + 12'h1)
      else $error("counter did not step up");
   count_wrap_a: assert property (
      calm && !c[33] && pwm_count == c[11:0] |=> pwm_count == 12'h0)
      else $error("counter did not wrap at top");
   count_down_a: assert property (
      calm && c[33] && count_down && pwm_count != 12'h0 |=> pwm_count == $past(pwm_count) - 12'h1)
      else $error("centre count did not step down");
   zero_pulse_a: assert property (
      calm |-> pulse_zero == ((pwm_count == 12'h0) ^ c[46]))
      else $error("zero pulse wrong");
   mode_off_a: assert property (
      calm && (c[30:28] == `MODE_OFF || c[30]) |-> gate_high[3] == c[41] && gate_low[3] == c[40])
      else $error("channel four not idle");
   no_overlap_a: assert property (
      compl0 |-> !(gate_high[0] && gate_low[0]))
      else $error("both gates of channel one on");
   dead_low_a: assert property (
      compl0 ##0 $rose(gate_low[0]) && c[55:48] != 8'h0 |-> !gate_high[0] && !$past(gate_high[0]))
      else $error("low gate on without gap");
   dead_high_a: assert property (
      compl0 ##0 $rose(gate_high[0]) && c[63:56] != 8'h0 |-> !gate_low[0] && !$past(gate_low[0]))
      else $error("high gate on without gap");
endmodule // pwm_bridge_sva

bind four_channel_bridge_pwm pwm_bridge_sva #(.CH(CH), .CW(CW)) u_sva (
   .ref_clk, .nrst, .net_wr_en, .net_wr_index, .net_wr_data, .host_wr_en, .host_wr_index,
   .host_wr_data, .gate_high, .gate_low, .pulse_zero, .pwm_count, .count_down);

// [sim/gate_driver_model.sv]
// Gate driver model of four bridge legs that counts cycles with a leg shorted
module gate_driver_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Gate pins and their inversion
   input  wire logic       watch,
   input  wire logic [3:0] gate_high,
   input  wire logic [3:0] gate_low,
   input  wire logic       inv_high,
   input  wire logic       inv_low,
   // Shorted cycles seen
   output logic      [7:0] overlap
);
   timeunit 1ns;
   timeprecision 1ns;
   // Switch state with the pin polarity taken away
   wire [3:0] hi_on = gate_high ^ {4{inv_high}};
   wire [3:0] lo_on = gate_low ^ {4{inv_low}};
   // A leg with both switches closed is a short
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) overlap <= 8'h00;
      else if (watch && (hi_on & lo_on) != 4'h0) overlap <= overlap + 8'h01;
   end
endmodule // gate_driver_model

// [sim/four_channel_bridge_pwm_tb.sv]
// Self-checking bench of the four-channel bridge PWM
`include "pwm_bridge_map.vh"
module four_channel_bridge_pwm_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ********
   // Stimulus state
   // ********
   logic             ref_clk = 1'b0;
   logic             nrst = 1'b0;
   logic             net_wr_en = 1'b0;
   logic             host_wr_en = 1'b0;
   logic [5:0]       net_wr_index = 6'h00;
   logic [5:0]       host_wr_index = 6'h00;
   logic [63:0]      net_wr_data = 64'h0;
   logic [63:0]      host_wr_data = 64'h0;
   logic [63:0]      hx = 64'h0;
   logic             watch = 1'b0;
   logic [11:0]      top = 12'h0;
   logic [1:0]       al = 2'h0;
   logic [3:0][2:0]  m = '0;
   logic [3:0][11:0] du = '0;
   logic [6:0]       pol = 7'h00;
   wire  [3:0]       gate_high;
   wire  [3:0]       gate_low;
   wire              pulse_zero;
   wire              pulse_center;
   wire              pulse_a;
   wire              pulse_b;
   wire              pulse_ab;
   wire  [11:0]      pwm_count;
   wire  [7:0]       overlap;
   int               n_mismatch = 0;
   int               samples_checked = 0;
   // Clock of 50 ns
   always #25 ref_clk = ~ref_clk;
   four_channel_bridge_pwm DUT (.ref_clk, .nrst, .net_wr_en, .net_wr_index, .net_wr_data,
      .host_wr_en, .host_wr_index, .host_wr_data, .pulse_a_pos(12'h001), .pulse_b_pos(12'h002),
      .gate_high, .gate_low, .pulse_zero, .pulse_center, .pulse_a, .pulse_b, .pulse_ab,
      .pwm_count, .count_down());
   gate_driver_model u_drv (.ref_clk, .nrst, .watch, .gate_high, .gate_low,
      .inv_high(pol[1]), .inv_low(pol[0]), .overlap);
   // Verdict and end of run
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic miss(input string s);
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, s);
   endtask
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      samples_checked++;
      if (g !== e) miss($sformatf("got %h, expected %h", g, e));
   endtask
   // One write cycle; bit 0 strobes the net port, bit 1 the host port
   task automatic wr(input logic [1:0] s, input logic [5:0] i, input logic [63:0] d);
      @(posedge ref_clk);
      #1;
      {host_wr_en, net_wr_en} = s;
      net_wr_index = i;
      host_wr_index = i;
      net_wr_data = d;
      host_wr_data = d ^ hx;
      @(posedge ref_clk);
      #1;
      {host_wr_en, net_wr_en} = 2'b00;
   endtask
   task automatic setup(input logic [1:0] s, input logic [11:0] t, input logic [1:0] a,
      input logic [3:0][2:0] mm, input logic [3:0][11:0] d, input logic [6:0] p,
      input logic [7:0] l, input logic [7:0] h);
      top = t;
      al = a;
      m = mm;
      du = d;
      pol = p;
      wr(s, `IDX_CONFIG, {h, l, 1'b0, p, 6'h00, a, 1'b0, mm[3], 1'b0, mm[2], 1'b0, mm[1],
         1'b0, mm[0], 4'h0, t});
      for (int i = 0; i < 4; i++) wr(s, 6'(`IDX_DUTY_ONE + i), {52'hf_ffff_ffff_ffff, d[i]});
   endtask
   // Follows the counter from zero and checks each cycle against own reckoning
   task automatic run_period(input int n);
      int          k;
      logic        up;
      logic [11:0] p;
      logic [11:0] nx;
      logic [3:0]  a;
      logic [3:0]  eh;
      logic [3:0]  el;
      k = 0;
      up = 1'b1;
      p = 12'h0;
      while (pwm_count !== 12'h0) begin
         @(posedge ref_clk);
         #2;
         k++;
         if (k > 9000) begin
            miss("counter never at zero");
            report_and_stop;
         end
      end
      watch = 1'b1;
      repeat (n) begin
         @(posedge ref_clk);
         #2;
         if (al[1] && p == top) up = 1'b0;
         if (p == 12'h0) up = 1'b1;
         nx = (!al[1] && p == top) ? 12'h0 : (up ? p + 12'h1 : p - 12'h1);
         for (int i = 0; i < 4; i++) begin
            a[i] = ((al == `ALIGN_RIGHT) ? top - p : p) < du[i];
            eh[i] = ((m[i] == `MODE_COMPL || m[i] == `MODE_HIGH_ONLY) && a[i]) ^ pol[1];
            el[i] = ((m[i] == `MODE_COMPL && !a[i]) || (m[i] == `MODE_LOW_ONLY && a[i])) ^ pol[0];
         end
         chk(pwm_count, nx);
         chk({8'h0, gate_high}, {8'h0, eh});
         chk({8'h0, gate_low}, {8'h0, el});
         chk({11'h0, pulse_zero}, {11'h0, (nx == 12'h0) ^ pol[6]});
         chk({8'h0, pulse_ab, pulse_b, pulse_a, pulse_center},
            {8'h0, ((nx == 12'h1) | (nx == 12'h2)) ^ pol[2], (nx == 12'h2) ^ pol[3],
             (nx == 12'h1) ^ pol[5], (nx == top) ^ pol[4]});
         p = nx;
      end
      watch = 1'b0;
   endtask
   // Cycles from bit f of {low, high} falling to bit r rising
   task automatic gap(input int f, input int r, input logic [11:0] e);
      int         tf;
      logic       ok;
      logic [1:0] v;
      logic [1:0] pv;
      tf = -1;
      ok = 1'b0;
      watch = 1'b1;
      v = {gate_low[0], gate_high[0]};
      for (int k = 0; k < 60 && !ok; k++) begin
         pv = v;
         @(posedge ref_clk);
         #2;
         v = {gate_low[0], gate_high[0]};
         if (pv[f] && !v[f]) tf = k;
         if (tf >= 0 && !pv[r] && v[r]) begin
            chk(12'(k - tf), e);
            ok = 1'b1;
         end
      end
      watch = 1'b0;
      if (!ok) begin
         miss("no gate edge seen");
         report_and_stop;
      end
   endtask
   // ********
   // Main sequence
   // ********
   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      run_period(4);
      $display("Test reset state done");
      setup(2'b01, 12'h3, `ALIGN_LEFT, {3'h0, 3'h3, 3'h2, 3'h1}, 48'h004_003_000_002,
         7'h00, 8'h00, 8'h00);
      run_period(12);
      $display("Test left alignment done");
      setup(2'b10, 12'h5, `ALIGN_RIGHT, {3'h2, 3'h5, 3'h1, 3'h1}, 48'h006_001_005_002,
         7'h01, 8'h00, 8'h00);
      run_period(14);
      $display("Test right alignment done");
      setup(2'b01, 12'h4, `ALIGN_CENTER, {3'h7, 3'h2, 3'h3, 3'h1}, 48'h002_004_003_001,
         7'h42, 8'h00, 8'h00);
      run_period(18);
      $display("Test centre alignment done");
      setup(2'b01, 12'hb, `ALIGN_LEFT, {3'h0, 3'h0, 3'h0, 3'h1}, 48'h000_000_000_006,
         7'h00, 8'h07, 8'h0b);
      gap(0, 1, 12'h2);
      gap(1, 0, 12'h3);
      $display("Test dead time done");
      hx = 64'h4;
      setup(2'b11, 12'h3, `ALIGN_LEFT, {3'h0, 3'h3, 3'h2, 3'h1}, 48'h004_003_000_002,
         7'h3c, 8'h00, 8'h00);
      wr(2'b01, 6'h29, 64'hffff_ffff_ffff_ffff);
      wr(2'b10, 6'h23, 64'hffff_ffff_ffff_ffff);
      run_period(12);
      chk({4'h0, overlap}, 12'h0);
      $display("Test port priority done");
      @(posedge ref_clk);
      #1;
      nrst = 1'b0;
      #2;
      chk(pwm_count, 12'h0);
      chk({8'h0, gate_high | gate_low}, 12'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      setup(2'b00, 12'h0, 2'h0, '0, '0, 7'h00, 8'h00, 8'h00);
      run_period(4);
      chk({4'h0, overlap}, 12'h0);
      $display("Test second reset done");
      report_and_stop;
   end
endmodule // four_channel_bridge_pwm_tb
